// ### verilog/rtcdef_pkg.sv
package rtcdef_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TONE_HZ = 512;
    // half period of the test tone in ref_clk cycles (rounded down)
    localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int unsigned TRIM_LOAD_MS = 8;
    localparam int unsigned TRIM_LOAD_CYC = (CLK_HZ / 1000) * TRIM_LOAD_MS;

    // register byte offsets
    localparam logic [7:0] OFS_DIG_TRIM = 8'h08;
    localparam logic [7:0] OFS_WDOG = 8'h09;
    localparam logic [7:0] OFS_ALM1_MON = 8'h0a;
    localparam logic [7:0] OFS_ALM1_RPT = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h0f;
    localparam logic [7:0] OFS_TMR_CTL = 8'h11;
    localparam logic [7:0] OFS_CENT = 8'h14;
    localparam logic [7:0] OFS_MISC = 8'h18;
    localparam logic [7:0] OFS_ALM2 = 8'h1c;
    localparam logic [7:0] OFS_ANA_TRIM = 8'h12;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // field positions
    localparam int unsigned DT_OUT_BIT = 7;
    localparam int unsigned DT_TEST_EN_BIT = 6;
    localparam int unsigned DT_SIGN_BIT = 5;

    // first power-up reset values
    localparam logic [7:0] RST_DIG_TRIM = 8'h80;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_ALM1_MON = 8'h00;
    localparam logic [7:0] RST_ALM1_RPT = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h44; // halt_update and osc_fail_flag both start set
    localparam logic [7:0] RST_TMR_CTL = 8'h03;
    localparam logic [7:0] RST_CENT = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h11;
    localparam logic [7:0] RST_ALM2 = 8'h00;
    localparam logic [7:0] RST_ANA_TRIM = 8'h00;

    // persistent control image (all loose bits gathered)
    typedef struct packed {
        logic [7:0] dig_trim;  // out, freq_test_enable, sign, 5b trim
        logic [7:0] wdog;      // osc_fail_irq_en, wdog_multiplier[4:0], resolution hi/lo
        logic [7:0] alm1_mon;  // alarm1_irq_en, -, alarm_backup_en
        logic [7:0] alm1_rpt;  // alarm1_repeat_bits[4:0]
        logic [7:0] flags;     // halt_update bit6, osc_fail_flag bit2, osc_stop bit7
        logic [7:0] tmr_ctl;   // timer_en7, pulse_sel6, irq_en5, clk_sel hi1/lo0
        logic [7:0] cent;      // century hi7/lo6, analog_trim_sign5
        logic [7:0] misc;      // square_wave_en4, trim_lock3, rate hi2:1, rate lo0
        logic [7:0] alm2;      // alarm2_irq_en7, alarm2_enable6, alarm2_repeat_bits[4:0]
        logic [7:0] ana_trim;
    } rtcdef_ctl_s;

    localparam rtcdef_ctl_s RST_CTL = '{RST_DIG_TRIM, RST_WDOG, RST_ALM1_MON, RST_ALM1_RPT,
        RST_FLAGS, RST_TMR_CTL, RST_CENT, RST_MISC, RST_ALM2, RST_ANA_TRIM};

    // misc register fields
    localparam int unsigned MISC_SQW_EN_BIT = 4;
    localparam int unsigned MISC_LOCK_BIT = 3;
    // flags / timer fields cleared or set on a battery-backed power-up
    localparam int unsigned FLG_HALT_BIT = 6;
    localparam int unsigned TMR_RUN_BIT = 7;
endpackage

// ### verilog/rtcdef_tone.sv
`timescale 1ns/1ns
// free-running square tone divider; restarts low while disabled
module rtcdef_tone #(
    parameter int unsigned HALF_CYC = 122070
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    output logic tone_o
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    if (HALF_CYC < 1) begin : g_bad_half
        $error("half period must be at least one cycle");
    end
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic tone_r, tone_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tone_nxt = tone_r;
        if (!en_i) begin
            cnt_nxt = '0;
            tone_nxt = 1'b0;
        end else if (cnt_r == CW'(HALF_CYC - 1)) begin
            cnt_nxt = '0;
            tone_nxt = ~tone_r;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
            tone_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tone_r <= tone_nxt;
        end
    end
    assign tone_o = tone_r;
endmodule

// ### verilog/rtcdef_core.sv
`timescale 1ns/1ns
// Behaviour
// - freq_test_enable at 1 drives a 512 Hz square tone on the shared pin
// - test off and supply good: shared pin held high, reset not asserted
// - supply fails during test: clear freq_test_enable, drive pin low
// - every power-up leaves freq_test_enable at 0, pin works as reset
// - first power-up and backup defaults for trim, watchdog, alarm1, century bits
// - first power-up and backup defaults for flags, timer, rate, alarm2, lock bits
// - unlisted control bits may power up undetermined; no forcing needed
// - trim lock set: copy factory trim to analog trim, make it read-only
// - trim lock clear: analog trim is ordinary read/write storage
// - factory trim copy completes about 8 ms after lock is set
module rtcdef_core #(
    parameter int unsigned TRIM_LOAD_CYC = rtcdef_pkg::TRIM_LOAD_CYC,
    parameter int unsigned TONE_HALF_CYC = rtcdef_pkg::TONE_HALF_CYC,
    parameter logic [7:0] FACTORY_TRIM = 8'h00
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic supply_good_i,
    input wire logic backup_valid_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic test_or_reset_pin_o,
    output logic test_or_reset_pin_oe_o,
    output logic trim_loading_o
);
    localparam int unsigned LW = $clog2(TRIM_LOAD_CYC + 1);
    // refuse a zero copy time: the counter compares against count minus one
    if (TRIM_LOAD_CYC < 1) begin : g_bad_load
        $error("trim load count must be at least one cycle");
    end

    // supply-good through three flops; a change counts when the last two agree
    logic [2:0] sg_sync_r, sg_sync_nxt;
    logic sg_r, sg_nxt;
    always_comb begin
        sg_sync_nxt = {sg_sync_r[1:0], supply_good_i};
        sg_nxt = sg_r;
        if (sg_sync_r[2] == sg_sync_r[1]) begin
            sg_nxt = sg_sync_r[1];
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sg_sync_r <= 3'h0;
            sg_r <= 1'b0;
        end else begin
            sg_sync_r <= sg_sync_nxt;
            sg_r <= sg_nxt;
        end
    end

    // start-up phases: settle, apply power-up image, then serve the bus
    typedef enum logic [2:0] {
        PH_INIT = 3'b001,
        PH_WAIT = 3'b010,
        PH_RUN = 3'b100
    } rtcdef_st_e;
    rtcdef_st_e st_r, st_nxt;
    // backup strap through three flops that keep running under reset,
    // so the value read in PH_WAIT has already settled
    logic [2:0] bk_sync_r, bk_sync_nxt;

    rtcdef_pkg::rtcdef_ctl_s ctl_r, ctl_nxt;
    logic [LW-1:0] load_cnt_r, load_cnt_nxt;
    logic loading_r, loading_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic tone;

    // register map as the host sees it, one byte per address
    //   0x08 digital trim control
    //        bit 7 discrete output level, starts at 1
    //        bit 6 freq_test_enable, always 0 after any power-up
    //        bit 5 digital_trim_sign
    //        bits 4:0 digital trim magnitude
    //   0x09 watchdog
    //        bit 7 osc_fail_irq_en
    //        bits 6:2 wdog_multiplier
    //        bits 1:0 wdog_resolution_hi / wdog_resolution_lo
    //        the watchdog fields clear on every power-up, the enable only on a first power-up
    //   0x0a alarm 1 month
    //        bit 7 alarm1_irq_en
    //        bit 5 alarm_backup_en
    //   0x0c alarm 1 repeat
    //        bits 4:0 alarm1_repeat_bits
    //   0x0f flags
    //        bit 7 osc_stop
    //        bit 6 halt_update, set on every power-up
    //        bit 2 osc_fail_flag, set on a first power-up only
    //   0x11 timer control
    //        bit 7 timer_en, cleared on every power-up
    //        bit 6 timer_pulse_sel
    //        bit 5 timer_irq_en
    //        bits 1:0 timer_clk_sel_hi / timer_clk_sel_lo, both start at 1
    //   0x12 analog trim
    //        plain storage while the trim lock is clear
    //        read-only factory value once the lock is set and the copy is done
    //   0x14 century
    //        bits 7:6 century_bit_hi / century_bit_lo
    //        bit 5 analog_trim_sign
    //   0x18 miscellaneous control
    //        bit 4 square_wave_en, starts at 1
    //        bit 3 factory trim lock
    //        bits 2:1 sqw_rate_sel_hi
    //        bit 0 sqw_rate_sel_lo, starts at 1
    //   0x1c alarm 2
    //        bit 7 alarm2_irq_en
    //        bit 6 alarm2_enable
    //        bits 4:0 alarm2_repeat_bits
    //   0x20 status, read-only
    //        bit 1 factory copy running
    //        bit 0 synchronised supply-good
    //   every other address reads zero and ignores writes
    //
    // power-up handling
    //   a first power-up loads the whole default image in PH_WAIT
    //   a battery-backed power-up keeps the held image and only touches
    //   the test enable, the watchdog fields, halt_update and timer_en
    //   the image flops carry no reset for that reason; in simulation the
    //   image is unknown until the first PH_WAIT has loaded it
    //   bits without a listed default simply come up as zero here
    //
    // shared test/reset pin
    //   the pin is open drain: the enable pulls it low, the pull-up lifts it
    //   while the supply is bad or start-up is not finished the pin is pulled,
    //   so the host sees reset asserted until the block is serving the bus
    //   with test enabled the tone low phase pulls the pin and the high phase
    //   releases it; the tone divider restarts low whenever it is disabled
    //   the supply-good input is three flops deep, so a failure reaches the
    //   pin a few cycles after the monitor drops; the monitor is expected
    //   to flag a failure early enough for that lag not to matter
    //   a supply failure clears the test enable, and that clear beats a host
    //   write of the same bit in the same cycle
    //
    // factory trim copy
    //   a rising trim lock starts a counted copy; the analog trim takes the
    //   factory value only when the count expires, mimicking the slow read
    //   of the factory store, and the status bit shows the copy running
    //   clearing the lock aborts a running copy and leaves the old value
    //   host writes to the analog trim are dropped for as long as the lock
    //   is set, including while the copy is still running
    //   the copy time is a parameter so a test can shorten it; the default
    //   matches the documented wait at the reference clock rate
    //
    // read path
    //   read data are registered: they stand in the cycle after the read
    //   strobe and are zero in every other cycle, so a bus that ORs several
    //   slaves together needs no extra gating
    //   reads of the image take the value before any write in the same cycle

    function automatic logic [7:0] rd_mux(input logic [7:0] a, input rtcdef_pkg::rtcdef_ctl_s c,
                                           input logic sg, input logic ld);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            rtcdef_pkg::OFS_DIG_TRIM: v = c.dig_trim;
            rtcdef_pkg::OFS_WDOG: v = c.wdog;
            rtcdef_pkg::OFS_ALM1_MON: v = c.alm1_mon;
            rtcdef_pkg::OFS_ALM1_RPT: v = c.alm1_rpt;
            rtcdef_pkg::OFS_FLAGS: v = c.flags;
            rtcdef_pkg::OFS_TMR_CTL: v = c.tmr_ctl;
            rtcdef_pkg::OFS_CENT: v = c.cent;
            rtcdef_pkg::OFS_MISC: v = c.misc;
            rtcdef_pkg::OFS_ALM2: v = c.alm2;
            rtcdef_pkg::OFS_ANA_TRIM: v = c.ana_trim;
            rtcdef_pkg::OFS_STATUS: v = {6'h00, ld, sg};
            default: v = 8'h00; // unmapped reads as zero
        endcase
        return v;
    endfunction

    // control image: power-up defaults, register writes, supply-fail and trim lock
    always_comb begin
        st_nxt = st_r;
        bk_sync_nxt = {bk_sync_r[1:0], backup_valid_i};
        ctl_nxt = ctl_r;
        load_cnt_nxt = load_cnt_r;
        loading_nxt = loading_r;
        rdata_nxt = 8'h00;
        unique case (st_r)
            PH_INIT: begin
                st_nxt = PH_WAIT;
            end
            PH_WAIT: begin
                // first power-up loads the default image; backup keeps the held image
                st_nxt = PH_RUN;
                if (bk_sync_r[2] && bk_sync_r[1]) begin
                    ctl_nxt.flags[rtcdef_pkg::FLG_HALT_BIT] = 1'b1;
                    ctl_nxt.tmr_ctl[rtcdef_pkg::TMR_RUN_BIT] = 1'b0;
                    ctl_nxt.wdog[6:0] = 7'h00;
                end else begin
                    ctl_nxt = rtcdef_pkg::RST_CTL;
                end
                ctl_nxt.dig_trim[rtcdef_pkg::DT_TEST_EN_BIT] = 1'b0;
            end
            PH_RUN: begin
                if (wr_i) begin
                    unique case (addr_i)
                        rtcdef_pkg::OFS_DIG_TRIM: ctl_nxt.dig_trim = wdata_i;
                        rtcdef_pkg::OFS_WDOG: ctl_nxt.wdog = wdata_i;
                        rtcdef_pkg::OFS_ALM1_MON: ctl_nxt.alm1_mon = wdata_i;
                        rtcdef_pkg::OFS_ALM1_RPT: ctl_nxt.alm1_rpt = wdata_i;
                        rtcdef_pkg::OFS_FLAGS: ctl_nxt.flags = wdata_i;
                        rtcdef_pkg::OFS_TMR_CTL: ctl_nxt.tmr_ctl = wdata_i;
                        rtcdef_pkg::OFS_CENT: ctl_nxt.cent = wdata_i;
                        rtcdef_pkg::OFS_MISC: ctl_nxt.misc = wdata_i;
                        rtcdef_pkg::OFS_ALM2: ctl_nxt.alm2 = wdata_i;
                        rtcdef_pkg::OFS_ANA_TRIM: begin
                            if (!ctl_r.misc[rtcdef_pkg::MISC_LOCK_BIT]) begin
                                ctl_nxt.ana_trim = wdata_i;
                            end
                        end
                        default: ;
                    endcase
                end
                // a rising lock bit starts the factory copy
                if (ctl_nxt.misc[rtcdef_pkg::MISC_LOCK_BIT] && !ctl_r.misc[rtcdef_pkg::MISC_LOCK_BIT]) begin
                    loading_nxt = 1'b1;
                    load_cnt_nxt = '0;
                end else if (!ctl_nxt.misc[rtcdef_pkg::MISC_LOCK_BIT]) begin
                    loading_nxt = 1'b0;
                end else if (loading_r) begin
                    if (load_cnt_r == LW'(TRIM_LOAD_CYC - 1)) begin
                        loading_nxt = 1'b0;
                        ctl_nxt.ana_trim = FACTORY_TRIM;
                    end else begin
                        load_cnt_nxt = load_cnt_r + 1'b1;
                    end
                end
                // supply failure overrides any write of the test bit
                if (!sg_r) begin
                    ctl_nxt.dig_trim[rtcdef_pkg::DT_TEST_EN_BIT] = 1'b0;
                end
                if (rd_i) begin
                    rdata_nxt = rd_mux(addr_i, ctl_r, sg_r, loading_r);
                end
            end
            default: st_nxt = PH_INIT;
        endcase
    end

    // only listed bits carry defined values; the rest of each byte is simply zero here
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= PH_INIT;
            load_cnt_r <= '0;
            loading_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            load_cnt_r <= load_cnt_nxt;
            loading_r <= loading_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // image and strap carry no reset: a battery-backed start must find the image intact
    always_ff @(posedge ref_clk_i) begin
        bk_sync_r <= bk_sync_nxt;
        ctl_r <= ctl_nxt;
    end

    // tone only runs with supply good, so a failure stops it at once
    rtcdef_tone #(
        .HALF_CYC(TONE_HALF_CYC)
    ) u_tone (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .en_i(ctl_r.dig_trim[rtcdef_pkg::DT_TEST_EN_BIT] && sg_r),
        .tone_o(tone)
    );

    // open-drain pin: pull low for reset or tone low phase, release otherwise
    always_comb begin
        pin_oe_nxt = 1'b1;
        if (st_r == PH_RUN && sg_r) begin
            if (ctl_r.dig_trim[rtcdef_pkg::DT_TEST_EN_BIT]) begin
                pin_oe_nxt = ~tone;
            end else begin
                pin_oe_nxt = 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_oe_r <= 1'b1;
        end else begin
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign test_or_reset_pin_oe_o = pin_oe_r;
    assign test_or_reset_pin_o = 1'b0; // level driven while enabled is always low
    assign trim_loading_o = loading_r;
endmodule

// ### sim/rtcdef_core_sva.sv
`timescale 1ns/1ns
// port-level checker; helpers mirror the test and lock bits from bus writes
module rtcdef_core_sva #(
    parameter int unsigned TRIM_LOAD_CYC = 20,
    parameter int unsigned TONE_HALF_CYC = 4,
    parameter logic [7:0] FACTORY_TRIM = 8'h00
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic supply_good_i,
    input wire logic backup_valid_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic test_or_reset_pin_o,
    input wire logic test_or_reset_pin_oe_o,
    input wire logic trim_loading_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic tst_r, lock_r, oe_q;
    logic [7:0] hold_r, good_r;
    int load_r;
    // supply loss clears the mirror at once; the device lags by its sync flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tst_r <= 1'b0;
            lock_r <= 1'b0;
            oe_q <= 1'b1;
            hold_r <= 8'h00;
            good_r <= 8'h00;
            load_r <= 0;
        end else begin
            tst_r <= supply_good_i && ((wr_i && addr_i == 8'h08) ? wdata_i[6] : tst_r);
            lock_r <= (wr_i && addr_i == 8'h18) ? wdata_i[3] : lock_r;
            oe_q <= test_or_reset_pin_oe_o;
            hold_r <= (test_or_reset_pin_oe_o != oe_q) ? 8'h00 : hold_r + {7'h00, hold_r != 8'hff};
            good_r <= (supply_good_i && !tst_r) ? good_r + {7'h00, good_r != 8'hff} : 8'h00;
            load_r <= trim_loading_o ? load_r + 1 : 0;
        end
    end
    sequence s_lock_wr;
        wr_i && addr_i == 8'h18 && wdata_i[3] && !lock_r;
    endsequence
    a_read_window: assert property (rdata_o != 8'h00 |-> $past(rd_i))
        else $error("read data outside its cycle");
    a_pin_open_drain: assert property (test_or_reset_pin_o == 1'b0)
        else $error("pin level not low");
    a_supply_fail: assert property (!supply_good_i [*6] |-> test_or_reset_pin_oe_o)
        else $error("reset not driven on supply loss");
    a_run_high: assert property (good_r >= 8'd10 |-> !test_or_reset_pin_oe_o)
        else $error("pin pulled with test off and supply good");
    a_tone_half: assert property (tst_r && $past(tst_r, 5) && supply_good_i && $past(supply_good_i, 5)
        && test_or_reset_pin_oe_o != oe_q |-> hold_r == TONE_HALF_CYC - 1)
        else $error("tone half period wrong");
    a_load_start: assert property (s_lock_wr |=> trim_loading_o)
        else $error("trim copy not started");
    a_load_len: assert property ($fell(trim_loading_o) && lock_r
        |-> load_r >= TRIM_LOAD_CYC - 1 && load_r <= TRIM_LOAD_CYC + 1)
        else $error("trim copy length wrong");
    a_lock_value: assert property (rd_i && addr_i == 8'h12 && lock_r && !trim_loading_o
        |=> rdata_o == FACTORY_TRIM)
        else $error("locked trim not factory value");
endmodule

bind rtcdef_core rtcdef_core_sva #(.TRIM_LOAD_CYC(TRIM_LOAD_CYC), .TONE_HALF_CYC(TONE_HALF_CYC),
    .FACTORY_TRIM(FACTORY_TRIM)) i_rtcdef_core_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .supply_good_i(supply_good_i), .backup_valid_i(backup_valid_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .test_or_reset_pin_o(test_or_reset_pin_o),
    .test_or_reset_pin_oe_o(test_or_reset_pin_oe_o), .trim_loading_o(trim_loading_o));

// ### sim/rtcdef_host.sv
`timescale 1ns/1ns
// host end of the open-drain pin: pull-up level and count of low pulses
module rtcdef_host (
    input wire logic pin_i,
    input wire logic oe_i,
    output logic lvl_o,
    output int falls_o
);
    assign lvl_o = oe_i ? pin_i : 1'b1;
    initial falls_o = 0;
    // each tone period gives one falling edge
    always @(negedge lvl_o) falls_o <= falls_o + 1;
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] FACT = 8'h5a;
    localparam logic [7:0] AD [10] = '{8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0f, 8'h11, 8'h14, 8'h18, 8'h1c, 8'h12};
    localparam logic [7:0] RV [10] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h44, 8'h03, 8'h00, 8'h11, 8'h00, 8'h00};
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, supply_good_i = 1'b1, backup_valid_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0, pin_o, oe_o, loading_o, lvl;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
    int falls, f0, n, err_total = 0, checks_done = 0, cyc = 0, seed = 42;
    int mdl [int];
    rtcdef_core #(.TRIM_LOAD_CYC(20), .TONE_HALF_CYC(4), .FACTORY_TRIM(FACT)) i_rtcdef_core (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .supply_good_i(supply_good_i),
        .backup_valid_i(backup_valid_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .test_or_reset_pin_o(pin_o), .test_or_reset_pin_oe_o(oe_o),
        .trim_loading_o(loading_o));
    rtcdef_host i_rtcdef_host (.pin_i(pin_o), .oe_i(oe_o), .lvl_o(lvl), .falls_o(falls));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    // hang guard, far above the roughly 160 cycles the tests need
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim;
        end
    end
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // model skips trim writes while locked, as the device refuses them
    task wr(input logic [7:0] a, input logic [7:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
        if (!(a == 8'h12 && mdl[8'h18][3])) mdl[a] = v;
    endtask
    task rd(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", mdl.exists(a) ? mdl[a][7:0] : 8'h00, rdata_o);
    endtask
    task wait_n(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task rst_run(input logic bk);
        rst_b_i <= 1'b0;
        backup_valid_i <= bk;
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        wait_n(8);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 10; i++) mdl[AD[i]] = RV[i];
        rst_run(1'b0);
        for (int i = 0; i < 10; i++) rd(AD[i]);
        chk("pin", 8'h01, {7'h00, lvl});
        mdl[8'h20] = 8'h01;
        rd(8'h20);
        $display("test defaults done");
        wr(8'h08, 8'hc0);
        f0 = falls;
        wait_n(40);
        chk("falls", 8'h01, {7'h00, falls - f0 >= 4});
        rd(8'h08);
        $display("test tone done");
        supply_good_i <= 1'b0;
        wait_n(10);
        chk("pin", 8'h00, {7'h00, lvl});
        mdl[8'h20] = 8'h00;
        rd(8'h20);
        supply_good_i <= 1'b1;
        wait_n(10);
        mdl[8'h08] = 8'h80;
        rd(8'h08);
        chk("pin", 8'h01, {7'h00, lvl});
        $display("test supply done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            wr(8'h12, d);
            rd(8'h12);
        end
        rd(8'h30);
        $display("test trim_rw done");
        wr(8'h18, 8'h19);
        wait_n(1);
        chk("loading", 8'h01, {7'h00, loading_o});
        mdl[8'h20] = 8'h03;
        rd(8'h20);
        n = 0;
        while (loading_o !== 1'b0 && n < 100) begin
            wait_n(1);
            n++;
        end
        chk("load_time", 8'h01, {7'h00, n >= 16 && n <= 21});
        mdl[8'h12] = FACT;
        rd(8'h12);
        mdl[8'h20] = 8'h01;
        rd(8'h20);
        wr(8'h12, 8'h33);
        rd(8'h12);
        rd(8'h18);
        wr(8'h18, 8'h11);
        wr(8'h12, 8'h77);
        rd(8'h12);
        $display("test lock done");
        wr(8'h09, 8'hff);
        wr(8'h11, 8'he3);
        wr(8'h0a, 8'ha0);
        wr(8'h08, 8'hc0);
        rst_run(1'b1);
        mdl[8'h09] = 8'h80;
        mdl[8'h11] = 8'h63;
        mdl[8'h08] = 8'h80;
        for (int i = 0; i < 10; i++) rd(AD[i]);
        $display("test backup done");
        end_sim;
    end
endmodule
